// >>> design/usbdc_top.sv
/*
  Global control and status of the high speed device port: address, enable,
  pad control, remote wakeup, frame numbering, interrupt enable and status.
  Assumes line-side events arrive as one-cycle pulses or levels synchronous
  to clk_sys from the packet engine, and an Avalon-MM master on the bus.
*/
// Decided for this implementation: the Avalon-MM slave port.
module usbdc_top #(
  parameter int SUSPEND_CYC = usbdc_pkg::SUSPEND_CYCLES,
  parameter int RWAKE_CYC = usbdc_pkg::RWAKE_CYCLES,
  parameter int RESUME_CYC = usbdc_pkg::RESUME_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Line-side events and levels
  input wire logic usb_reset,
  input wire logic bus_reset_end,
  input wire usbdc_pkg::usbdc_sof_t sof,
  input wire logic line_idle_j,
  input wire logic line_active,
  input wire logic host_resume_end,
  input wire logic hs_mode,
  // Token address check
  input wire logic token_valid,
  input wire logic [usbdc_pkg::DEVICE_ADDRESS_FIELD_W-1:0] token_addr,
  output logic token_match,
  // Endpoint and channel interrupt sources
  input wire logic [usbdc_pkg::NUM_EPT-1:0] ept_irq,
  input wire logic [usbdc_pkg::NUM_DMA:1] dma_irq,
  // Controller and pad control
  output logic controller_enable,
  output logic core_reset,
  output usbdc_pkg::usbdc_pad_t pad,
  output logic resume_drive,
  output logic irq
);
  import usbdc_pkg::*;

  // ********************************************************
  // Declarations
  // ********************************************************
  logic ack;
  logic wr_take;
  logic [31:0] wmask;
  logic [31:0] wdata;
  logic [DEVICE_ADDRESS_FIELD_W-1:0] device_address_field;
  logic addr_en;
  logic detach;
  logic pulldown_disable;
  logic rwake;
  logic rwake_clr;
  logic [31:0] ien;
  logic [7:1] flags;
  logic [7:1] flag_set;
  logic [7:1] flag_clr;
  logic [NUM_EPT-1:0] ept_stat;
  logic [NUM_DMA:1] dma_stat;
  logic suspended;
  logic idle_done;
  logic rwake_done;
  logic drive_done;
  logic [FRAME_W-1:0] frame;
  logic [UFRAME_W-1:0] uframe;
  logic frame_number_crc_error;
  logic irq_src;
  logic [31:0] next_readdata;
  usbdc_rs_t rs_state;
  usbdc_rs_t next_rs_state;

  // ********************************************************
  // Avalon-MM slave handshake
  // ********************************************************
  // One wait cycle per access; the write lands on the edge waitrequest is low
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ack <= 1'b0;
    else
      ack <= (avs_read || avs_write) && !ack;
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign wr_take = avs_write && ack;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdata = avs_writedata & wmask;

  // Read data sampled in the wait cycle, stands on the accepting edge
  always_comb
  begin
    next_readdata = 32'h00000000;
    case (avs_address)
      ADDR_CTRL: next_readdata = {20'h00000, pulldown_disable, rwake, detach,
                                  controller_enable, addr_en, device_address_field};
      ADDR_FNUM: next_readdata = {frame_number_crc_error, 17'h00000, frame, uframe};
      ADDR_IEN: next_readdata = ien;
      ADDR_INTSTA: next_readdata = {1'b0, dma_stat, 9'h000, 1'b0, ept_stat,
                                    flags, hs_mode};
      default: next_readdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      avs_readdata <= 32'h00000000;
    else if (avs_read && !ack)
      avs_readdata <= next_readdata;
  end

  // ********************************************************
  // Device control register
  // ********************************************************
  // Bus reset outranks a firmware write landing in the same cycle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      device_address_field <= '0;
      addr_en <= 1'b0;
    end
    else if (usb_reset)
    begin
      device_address_field <= '0;
      addr_en <= 1'b0;
    end
    else if (wr_take && avs_address == ADDR_CTRL)
    begin
      if (avs_byteenable[0])
      begin
        device_address_field <= avs_writedata[DEVICE_ADDRESS_FIELD_W-1:0];
        if (avs_writedata[CTRL_ADDR_EN_BIT])
          addr_en <= 1'b1;
      end
    end
  end

  // Plain read-write controls
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      controller_enable <= CTRL_EN_RESET;
      detach <= CTRL_DETACH_RESET;
      pulldown_disable <= CTRL_PULLD_RESET;
    end
    else if (wr_take && avs_address == ADDR_CTRL && avs_byteenable[1])
    begin
      controller_enable <= avs_writedata[CTRL_EN_BIT];
      detach <= avs_writedata[CTRL_DETACH_BIT];
      pulldown_disable <= avs_writedata[CTRL_PULLD_BIT];
    end
  end

  // Core held in reset while disabled
  assign core_reset = !controller_enable;

  // Wakeup request: software set wins over the hardware clear
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rwake <= 1'b0;
    else if (wr_take && avs_address == ADDR_CTRL && wdata[CTRL_RWAKE_BIT])
      rwake <= 1'b1;
    else if (rwake_clr)
      rwake <= 1'b0;
  end

  // Token filter: zero is the only address until address state is entered
  assign token_match = token_valid
                       && (token_addr == (addr_en ? device_address_field : '0));

  // ********************************************************
  // Pad control
  // ********************************************************
  // Registered so the pads never glitch while a control write settles
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pad <= '{dp_pullup: 1'b0, dp_pulldown: 1'b0, dm_pulldown: 1'b0, suspend_n: 1'b0};
    else
    begin
      pad.dp_pullup <= !detach;
      pad.dp_pulldown <= detach && !pulldown_disable;
      pad.dm_pulldown <= !pulldown_disable;
      pad.suspend_n <= !detach;
    end
  end

  // ********************************************************
  // Suspend detection and remote wakeup
  // ********************************************************
  usbdc_timer #(
    .LIMIT(SUSPEND_CYC)
  ) u_idle (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(line_idle_j && controller_enable),
    .done(idle_done)
  );

  usbdc_timer #(
    .LIMIT(RWAKE_CYC)
  ) u_rwake (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(suspended),
    .done(rwake_done)
  );

  usbdc_timer #(
    .LIMIT(RESUME_CYC)
  ) u_drive (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(rs_state == RS_DRIVE),
    .done(drive_done)
  );

  // Suspend state, left on any line activity, host resume or bus reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      suspended <= 1'b0;
    else if (line_active || usb_reset || host_resume_end || drive_done)
      suspended <= 1'b0;
    else if (idle_done)
      suspended <= 1'b1;
  end

  // Resume sequencer; the 5 ms wait restarts if the bus wakes meanwhile
  always_comb
  begin
    next_rs_state = rs_state;
    case (rs_state)
      RS_IDLE: if (rwake) next_rs_state = RS_WAIT;
      RS_WAIT: if (rwake_done) next_rs_state = RS_DRIVE;
      RS_DRIVE: if (drive_done) next_rs_state = RS_IDLE;
      default: next_rs_state = RS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rs_state <= RS_IDLE;
    else
      rs_state <= next_rs_state;
  end

  assign rwake_clr = (rs_state == RS_DRIVE) && drive_done;
  assign resume_drive = (rs_state == RS_DRIVE);

  // ********************************************************
  // Frame numbering
  // ********************************************************
  usbdc_frame u_frame (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(controller_enable),
    .sof(sof),
    .frame(frame),
    .uframe(uframe),
    .crc_err(frame_number_crc_error)
  );

  // ********************************************************
  // Interrupt enable, status and clear
  // ********************************************************
  // Hardware set of end-of-reset enable wins over a firmware write
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ien <= IEN_RESET;
    else
    begin
      if (wr_take && avs_address == ADDR_IEN)
        ien <= ((ien & ~wmask) | wdata) & IEN_MASK;
      if (bus_reset_end)
        ien[FLAG_ENDRST] <= 1'b1;
    end
  end

  // Event sources of the sticky flags
  always_comb
  begin
    flag_set = '0;
    flag_set[FLAG_SUSP] = idle_done && !suspended;
    flag_set[FLAG_USOF] = controller_enable && sof.valid && sof.micro;
    flag_set[FLAG_SOF] = controller_enable && sof.valid && !sof.micro;
    flag_set[FLAG_ENDRST] = bus_reset_end;
    flag_set[FLAG_WAKE] = suspended && line_active && rs_state != RS_DRIVE;
    flag_set[FLAG_ENDRSM] = host_resume_end;
    flag_set[FLAG_UPSTR] = (rs_state == RS_WAIT) && rwake_done;
  end

  // Only the clear register touches flags; status writes fall through
  assign flag_clr = (wr_take && avs_address == ADDR_CLRINT) ? wdata[7:1] : '0;

  // A set in the same cycle as its clear survives
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      flags <= '0;
    else
      flags <= (flags & ~flag_clr) | flag_set;
  end

  // Endpoint and channel status follow their sources, gated by enable
  assign ept_stat = ept_irq & ien[IEN_EPT_LSB +: NUM_EPT];
  assign dma_stat = dma_irq & ien[IEN_DMA_LSB +: NUM_DMA];

  // Any enabled pending source, registered below so irq never glitches
  assign irq_src = |(flags & ien[7:1]) || |ept_stat || |dma_stat;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= irq_src;
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence bus_reset_seen;
    usb_reset;
  endsequence

  sequence ctrl_write_seen;
    wr_take && avs_address == ADDR_CTRL && avs_byteenable[1] && !usb_reset;
  endsequence

  sequence frame_start_seen;
    controller_enable && sof.valid && !sof.micro;
  endsequence

  addr_clear_a: assert property (bus_reset_seen |=> device_address_field == '0 && !addr_en)
    else $error("address not cleared after bus reset");

  token_filter_a: assert property (token_valid && !addr_en && token_addr != '0
    |-> !token_match)
    else $error("nonzero token matched outside address state");

  enable_write_a: assert property (ctrl_write_seen
    |=> controller_enable == $past(avs_writedata[CTRL_EN_BIT]) ##1 core_reset != controller_enable)
    else $error("enable bit did not follow write");

  pad_table_a: assert property (!$past(rst) |-> pad.dm_pulldown == !$past(pulldown_disable)
    && pad.dp_pullup == !$past(detach)
    && pad.dp_pulldown == ($past(detach) && !$past(pulldown_disable)))
    else $error("pad state does not follow controls");

  resume_wait_a: assert property ($rose(resume_drive) |-> $past(rwake_done) && $past(suspended))
    else $error("upstream resume without suspend wait");

  rwake_clear_a: assert property ($fell(resume_drive) && !$past(wr_take) |-> !rwake)
    else $error("wakeup request not cleared at resume end");

  uframe_reset_a: assert property (frame_start_seen ##1 !(sof.valid && controller_enable)
    |-> uframe == '0)
    else $error("microframe not cleared at frame start");

  frame_load_a: assert property (frame_start_seen and !sof.crc_err |=> frame == $past(sof.frame))
    else $error("frame number not loaded from SOF");

  set_wins_a: assert property (flag_set[FLAG_SOF] && flag_clr[FLAG_SOF] |=> flags[FLAG_SOF])
    else $error("flag lost against simultaneous clear");

  irq_gate_a: assert property (irq |-> $past(irq_src))
    else $error("interrupt without enabled source");

  bus_reset_done_en_a: assert property (bus_reset_end |=> ien[FLAG_ENDRST])
    else $error("end-of-reset enable not set by hardware");
endmodule

// >>> design/usbdc_pkg.sv
/*
  Shared constants and types of the device port global control block.
  Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package usbdc_pkg;
  // ********************************************************
  // Register byte addresses
  // ********************************************************
  localparam logic [31:0] ADDR_CTRL = 32'hFFF78000;
  localparam logic [31:0] ADDR_FNUM = 32'hFFF78004;
  localparam logic [31:0] ADDR_IEN = 32'hFFF78010;
  localparam logic [31:0] ADDR_INTSTA = 32'hFFF78014;
  localparam logic [31:0] ADDR_CLRINT = 32'hFFF78018;

  // ********************************************************
  // Field positions and reset values
  // ********************************************************
  localparam int DEVICE_ADDRESS_FIELD_W = 7;
  localparam int CTRL_ADDR_EN_BIT = 7;
  localparam int CTRL_EN_BIT = 8;
  localparam int CTRL_DETACH_BIT = 9;
  localparam int CTRL_RWAKE_BIT = 10;
  localparam int CTRL_PULLD_BIT = 11;
  localparam logic CTRL_EN_RESET = 1'b0;
  localparam logic CTRL_DETACH_RESET = 1'b1;
  localparam logic CTRL_PULLD_RESET = 1'b0;
  localparam int FRAME_W = 11;
  localparam int UFRAME_W = 3;
  localparam int FRAME_NUMBER_CRC_ERROR_BIT = 31;
  localparam logic [31:0] IEN_MASK = 32'h7E007FFE;
  localparam logic [31:0] IEN_RESET = 32'h00000000;
  localparam int IEN_EPT_LSB = 8;
  localparam int IEN_DMA_LSB = 25;
  localparam int NUM_EPT = 7;
  localparam int NUM_DMA = 6;

  // Status flag positions, shared by enable, status and clear registers
  localparam int FLAG_SUSP = 1;
  localparam int FLAG_USOF = 2;
  localparam int FLAG_SOF = 3;
  localparam int FLAG_ENDRST = 4;
  localparam int FLAG_WAKE = 5;
  localparam int FLAG_ENDRSM = 6;
  localparam int FLAG_UPSTR = 7;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_MHZ = 100;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int SUSPEND_IDLE_MS = 3;
  localparam int RWAKE_SUSP_MS = 5;
  localparam int RESUME_DRIVE_MS = 1;
  localparam int SUSPEND_CYCLES = SUSPEND_IDLE_MS * CYC_PER_MS;
  localparam int RWAKE_CYCLES = RWAKE_SUSP_MS * CYC_PER_MS;
  localparam int RESUME_CYCLES = RESUME_DRIVE_MS * CYC_PER_MS;

  // ********************************************************
  // Types
  // ********************************************************
  typedef struct packed {
    logic valid;
    logic micro;
    logic crc_err;
    logic [FRAME_W-1:0] frame;
  } usbdc_sof_t;

  typedef struct packed {
    logic dp_pullup;
    logic dp_pulldown;
    logic dm_pulldown;
    logic suspend_n;
  } usbdc_pad_t;

  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_WAIT = 2'b01,
    RS_DRIVE = 2'b10
  } usbdc_rs_t;
endpackage

// >>> design/usbdc_timer.sv
/*
  Saturating cycle counter that runs while a level is held.
  Assumes the run level is synchronous to clk_sys.
*/
module usbdc_timer #(
  parameter int LIMIT = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic run,
  output logic done
);
  import usbdc_pkg::*;
  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LIM = W'(LIMIT);
  logic [W-1:0] count;

  // Restarts from zero whenever run drops, so a broken interval never counts
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      count <= '0;
    else if (!run)
      count <= '0;
    else if (count != LIM)
      count <= count + 1'b1;
  end

  assign done = run && (count == LIM);
endmodule

// >>> design/usbdc_frame.sv
/*
  Frame and microframe numbering with frame number CRC error flag.
  Assumes one start-of-frame event per valid cycle from the packet decoder.
*/
module usbdc_frame (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Start of frame events
  input wire logic enable,
  input wire usbdc_pkg::usbdc_sof_t sof,
  // Frame state
  output logic [usbdc_pkg::FRAME_W-1:0] frame,
  output logic [usbdc_pkg::UFRAME_W-1:0] uframe,
  output logic crc_err
);
  import usbdc_pkg::*;

  // A corrupted frame number keeps the last good one; the error bit sets and uframe still clears
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      frame <= '0;
      uframe <= '0;
      crc_err <= 1'b0;
    end
    else if (enable && sof.valid)
    begin
      crc_err <= sof.crc_err;
      if (sof.micro)
        uframe <= uframe + 1'b1;
      else
      begin
        uframe <= '0;
        if (!sof.crc_err)
          frame <= sof.frame;
      end
    end
  end
endmodule

// >>> verification/usbdc_host_model.sv
/*
  Line-side host model: bus reset, SOF packets, idle J and speed.
  Assumes the bench calls its tasks at a rising clk_sys edge.
*/
module usbdc_host_model (
  // Clock
  input wire logic clk_sys,
  // Line events toward the device
  output logic usb_reset,
  output logic bus_reset_end,
  output usbdc_pkg::usbdc_sof_t sof,
  output logic line_idle_j,
  output logic line_active,
  output logic host_resume_end,
  output logic hs_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  import usbdc_pkg::*;
  // Quiet full speed line; host resume and activity are not modelled
  initial
  begin
    usb_reset = 1'b0;
    bus_reset_end = 1'b0;
    sof = 14'h0;
    line_idle_j = 1'b0;
    line_active = 1'b0;
    host_resume_end = 1'b0;
    hs_mode = 1'b0;
  end
  // One SOF pulse; fields turn to junk after so stale values cannot pass
  task sof_pkt(input logic m, input logic e, input logic [10:0] f);
    sof <= {1'b1, m, e, f};
    @(posedge clk_sys);
    sof <= {1'b0, ~m, ~e, ~f};
    @(posedge clk_sys);
  endtask
  // Bus reset followed by its end a few cycles later
  task bus_rst;
    usb_reset <= 1'b1;
    @(posedge clk_sys);
    usb_reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    bus_reset_end <= 1'b1;
    @(posedge clk_sys);
    bus_reset_end <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Line level and speed
  task level(input logic j, input logic hs);
    line_idle_j <= j;
    hs_mode <= hs;
    @(posedge clk_sys);
  endtask
endmodule

// >>> verification/test_usb_hs_device_global_ctrl.sv
/*
  Self-checking bench of the device port global control block.
  Assumes the package and the host line model are compiled first.
*/
module test_usb_hs_device_global_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import usbdc_pkg::*;
  // ********
  // Signals
  // ********
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [31:0] avs_address = 32'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic usb_reset, bus_reset_end, line_idle_j, line_active, host_resume_end, hs_mode;
  usbdc_sof_t sof;
  logic token_valid = 1'b1;
  logic [6:0] token_addr = 7'h0;
  logic token_match, controller_enable, core_reset, resume_drive, irq;
  logic [6:0] ept_irq = 7'h0;
  logic [6:1] dma_irq = 6'h0;
  usbdc_pad_t pad;
  logic [3:0] pad_exp [4] = '{4'hB, 4'h9, 4'h6, 4'h0};
  int errors = 0;
  int n_tests = 0;
  int n;
  int m;
  // Clock at 100 MHz
  always #5 clk_sys = ~clk_sys;
  // ********
  // Instances
  // ********
  // Short counts keep the wakeup path within a few hundred cycles
  usbdc_top #(.SUSPEND_CYC(20), .RWAKE_CYC(30), .RESUME_CYC(10)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .usb_reset(usb_reset), .bus_reset_end(bus_reset_end), .sof(sof),
    .line_idle_j(line_idle_j), .line_active(line_active),
    .host_resume_end(host_resume_end), .hs_mode(hs_mode), .token_valid(token_valid),
    .token_addr(token_addr), .token_match(token_match), .ept_irq(ept_irq),
    .dma_irq(dma_irq), .controller_enable(controller_enable), .core_reset(core_reset),
    .pad(pad), .resume_drive(resume_drive), .irq(irq));
  usbdc_host_model u_host (
    .clk_sys(clk_sys), .usb_reset(usb_reset), .bus_reset_end(bus_reset_end), .sof(sof),
    .line_idle_j(line_idle_j), .line_active(line_active),
    .host_resume_end(host_resume_end), .hs_mode(hs_mode));
  // ********
  // Tasks
  // ********
  task final_report;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Avalon access; request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50)
    begin
      errors++;
      final_report;
    end
    // Same edge: the write lands and read data is taken, then release
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Idle cycle so no strobe is assigned twice in one step
    @(posedge clk_sys);
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task tk(input logic [6:0] a, input logic e);
    token_addr <= a;
    @(negedge clk_sys);
    chk(32'(token_match), 32'(e));
    @(posedge clk_sys);
  endtask
  // ********
  // Sequence
  // ********
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk(32'(pad), 32'h6);
    @(posedge clk_sys);
    rc(ADDR_CTRL, 32'h200);
    rc(ADDR_FNUM, 32'h0);
    rc(ADDR_IEN, 32'h0);
    rc(ADDR_INTSTA, 32'h0);
    rc(ADDR_CLRINT, 32'h0);
    rc(32'hFFF78020, 32'h0);
    // Every detach and pull-down combination
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CTRL, 32'h100 | (32'(i[0]) << 11) | (32'(i[1]) << 9));
      @(negedge clk_sys);
      chk(32'(pad), 32'(pad_exp[i]));
      @(posedge clk_sys);
    end
    wr(ADDR_CTRL, 32'h0);
    chk({30'h0, controller_enable, core_reset}, 32'h1);
    wr(ADDR_CTRL, 32'hFFFFF100);
    rc(ADDR_CTRL, 32'h100);
    chk({30'h0, controller_enable, core_reset}, 32'h2);
    // Address and address state
    wr(ADDR_CTRL, 32'h155);
    tk(7'h0, 1'b1);
    tk(7'h55, 1'b0);
    wr(ADDR_CTRL, 32'h1D5);
    rc(ADDR_CTRL, 32'h1D5);
    tk(7'h55, 1'b1);
    tk(7'h0, 1'b0);
    wr(ADDR_CTRL, 32'h155);
    rc(ADDR_CTRL, 32'h1D5);
    u_host.bus_rst;
    rc(ADDR_CTRL, 32'h100);
    tk(7'h0, 1'b1);
    rc(ADDR_IEN, 32'h10);
    rc(ADDR_INTSTA, 32'h10);
    wr(ADDR_IEN, 32'hFFFFFFFF);
    rc(ADDR_IEN, 32'h7E007FFE);
    // SOF numbering, error bit and masking
    wr(ADDR_IEN, 32'h8);
    wr(ADDR_CLRINT, 32'hFE);
    u_host.sof_pkt(1'b0, 1'b0, 11'h123);
    @(negedge clk_sys);
    chk(32'(irq), 32'h1);
    @(posedge clk_sys);
    rc(ADDR_FNUM, 32'h918);
    repeat (3) u_host.sof_pkt(1'b1, 1'b0, 11'h0);
    rc(ADDR_FNUM, 32'h91B);
    wr(ADDR_CLRINT, 32'h8);
    // Registered irq settles one edge after the clear lands
    @(negedge clk_sys);
    chk(32'(irq), 32'h0);
    @(posedge clk_sys);
    u_host.sof_pkt(1'b0, 1'b1, 11'h456);
    rc(ADDR_FNUM, 32'h80000918);
    rc(ADDR_INTSTA, 32'hC);
    wr(ADDR_INTSTA, 32'hFFFFFFFF);
    rc(ADDR_INTSTA, 32'hC);
    wr(ADDR_CLRINT, 32'h4);
    rc(ADDR_INTSTA, 32'h8);
    wr(ADDR_CLRINT, 32'hFE);
    // SOF event lands on the same edge as its clear; the set must survive
    fork
      wr(ADDR_CLRINT, 32'h8);
      begin
        @(posedge clk_sys);
        u_host.sof_pkt(1'b0, 1'b0, 11'h456);
      end
    join
    rc(ADDR_INTSTA, 32'h8);
    wr(ADDR_CLRINT, 32'hFE);
    // Speed and endpoint or channel gating
    u_host.level(1'b0, 1'b1);
    ept_irq <= 7'h04;
    dma_irq <= 6'h01;
    rc(ADDR_INTSTA, 32'h1);
    wr(ADDR_IEN, 32'h02000400);
    rc(ADDR_INTSTA, 32'h02000401);
    chk(32'(irq), 32'h1);
    wr(ADDR_IEN, 32'h0);
    ept_irq <= 7'h0;
    dma_irq <= 6'h0;
    u_host.level(1'b1, 1'b0);
    // Remote wakeup waits for suspend, then drives resume
    wr(ADDR_CTRL, 32'h500);
    wr(ADDR_CTRL, 32'h100);
    rc(ADDR_CTRL, 32'h500);
    n = 0;
    while (resume_drive !== 1'b1 && n < 300)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(32'(resume_drive), 32'h1);
    chk(32'(n >= 35), 32'h1);
    m = 0;
    while (resume_drive === 1'b1 && m < 100)
    begin
      @(negedge clk_sys);
      m++;
    end
    // Drive holds for the timer limit plus the edge that ends it
    chk(m, 11);
    @(posedge clk_sys);
    rc(ADDR_CTRL, 32'h100);
    rc(ADDR_INTSTA, 32'h82);
    final_report;
  end
endmodule
